// >>> hw/pcr_pkg.sv
package pcr_pkg;
  // register indices as printed; byte address is four times the index
  localparam int PCR_AW = 8;
  localparam logic [PCR_AW-1:0] PCR_IDX_DUTY = 8'h18;
  localparam logic [PCR_AW-1:0] PCR_IDX_RATE = 8'h1C;
  localparam logic [PCR_AW-1:0] PCR_IDX_HWC3 = 8'h1D;
  localparam logic [PCR_AW-1:0] PCR_IDX_SCRL = 8'h1E;
  localparam logic [PCR_AW-1:0] PCR_IDX_SCRH = 8'h1F;
  localparam logic [PCR_AW-1:0] PCR_ADR_DUTY = PCR_IDX_DUTY << 2;
  localparam logic [PCR_AW-1:0] PCR_ADR_RATE = PCR_IDX_RATE << 2;
  localparam logic [PCR_AW-1:0] PCR_ADR_HWC3 = PCR_IDX_HWC3 << 2;
  localparam logic [PCR_AW-1:0] PCR_ADR_SCRL = PCR_IDX_SCRL << 2;
  localparam logic [PCR_AW-1:0] PCR_ADR_SCRH = PCR_IDX_SCRH << 2;

  // field layout
  localparam int PCR_DUTY_W = 8;
  localparam int PCR_RATE_W = 2;
  localparam int PCR_TRIM_W = 2;
  localparam int PCR_TRIM_LSB = 0;
  localparam int PCR_TSD_BIT = 2;
  localparam int PCR_CFG_W = 3;

  // reset values
  localparam logic [7:0] PCR_RST_DUTY = 8'h00;
  localparam logic [1:0] PCR_RST_RATE = 2'h0;
  localparam logic [7:0] PCR_RST_HWC3 = 8'h01;
  localparam logic [7:0] PCR_RST_SCR = 8'h00;

  // pin configuration codes that hand the pin to the pwm
  localparam logic [2:0] PCR_CFG_LS_PWM = 3'h6;
  localparam logic [2:0] PCR_CFG_HS_PWM = 3'h7;

  // time base: 255 steps per period
  localparam int PCR_CLK_HZ = 10_000_000;
  localparam int PCR_STEPS = 255;
  localparam logic [7:0] PCR_STEP_LAST = 8'hFE;
  localparam int PCR_F0_HZ = 100;
  localparam int PCR_F1_HZ = 200;
  localparam int PCR_F2_HZ = 325;
  localparam int PCR_F3_HZ = 400;
  localparam int PCR_PRE_W = 12;
  localparam logic [PCR_PRE_W-1:0] PCR_STEP_CYC0 =
    PCR_PRE_W'(PCR_CLK_HZ / (PCR_F0_HZ * PCR_STEPS));
  localparam logic [PCR_PRE_W-1:0] PCR_STEP_CYC1 =
    PCR_PRE_W'(PCR_CLK_HZ / (PCR_F1_HZ * PCR_STEPS));
  localparam logic [PCR_PRE_W-1:0] PCR_STEP_CYC2 =
    PCR_PRE_W'(PCR_CLK_HZ / (PCR_F2_HZ * PCR_STEPS));
  localparam logic [PCR_PRE_W-1:0] PCR_STEP_CYC3 =
    PCR_PRE_W'(PCR_CLK_HZ / (PCR_F3_HZ * PCR_STEPS));
endpackage : pcr_pkg

// >>> hw/pcr_pwm.sv
`timescale 1ns/100ps
module pcr_pwm #(
  parameter int DUTY_W = pcr_pkg::PCR_DUTY_W
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic soft_rst_i,
  input wire logic [DUTY_W-1:0] duty_i,
  input wire logic [pcr_pkg::PCR_RATE_W-1:0] rate_i,
  output logic on_o
);
  import pcr_pkg::*;

  typedef struct packed {
    logic [PCR_PRE_W-1:0] pre;
    logic [7:0] step;
    logic [DUTY_W-1:0] duty;
    logic [PCR_RATE_W-1:0] rate;
    logic on;
  } pcr_pwm_s;

  pcr_pwm_s st_ff;
  pcr_pwm_s nxt_st;
  logic [PCR_PRE_W-1:0] step_len;

  // prescaler, step counter, boundary latch and compare
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.rate)
      2'h0: step_len = PCR_STEP_CYC0;
      2'h1: step_len = PCR_STEP_CYC1;
      2'h2: step_len = PCR_STEP_CYC2;
      2'h3: step_len = PCR_STEP_CYC3;
    endcase
    if (st_ff.pre == step_len - PCR_PRE_W'(1)) begin
      nxt_st.pre = '0;
      if (st_ff.step == PCR_STEP_LAST) begin
        // new settings only at the period boundary
        nxt_st.step = 8'h00;
        nxt_st.duty = duty_i;
        nxt_st.rate = rate_i;
      end else begin
        nxt_st.step = st_ff.step + 8'h01;
      end
    end else begin
      nxt_st.pre = st_ff.pre + PCR_PRE_W'(1);
    end
    // soft reset restarts the period with cleared settings
    if (soft_rst_i) begin
      nxt_st = '0;
    end
    // step runs 0..254: 0 never on, 255 always on
    nxt_st.on = (nxt_st.step < nxt_st.duty);
  end

  // single state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign on_o = st_ff.on;

  AST_DUTY_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!soft_rst_i && st_ff.step != PCR_STEP_LAST) |=> $stable(st_ff.duty)
  ) else $error("duty changed inside a period");
  AST_RATE_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!soft_rst_i && st_ff.step != PCR_STEP_LAST) |=> $stable(st_ff.rate)
  ) else $error("rate changed inside a period");
  AST_ZERO_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_ff.duty == 8'h00 |-> !st_ff.on
  ) else $error("switch on with zero duty");
  AST_FULL_ON: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_ff.duty == 8'hFF |-> st_ff.on
  ) else $error("switch off with full duty");
endmodule : pcr_pwm

// >>> hw/pcr_regs.sv
`timescale 1ns/100ps
module pcr_regs (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // apb3 slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [pcr_pkg::PCR_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // device context, same clock domain
  input wire logic SOFT_RST_I,
  input wire logic NORMAL_MODE_I,
  input wire logic CFG_LOCK1_I,
  input wire logic [pcr_pkg::PCR_CFG_W-1:0] PIN_CFG_I,
  // controls to the rest of the device
  output logic HS_SWITCH_ON_O,
  output logic LS_SWITCH_ON_O,
  output logic THERMAL_TRIP_LEVEL_O,
  output logic [pcr_pkg::PCR_TRIM_W-1:0] REGULATOR_CURRENT_LIMIT_TRIM_O,
  output logic [15:0] SCRATCH_WORD_O
);
  import pcr_pkg::*;

  typedef struct packed {
    logic [PCR_DUTY_W-1:0] duty_setting;
    logic [PCR_RATE_W-1:0] period_rate_select;
    logic thermal_trip_level;
    logic [PCR_TRIM_W-1:0] regulator_current_limit_trim;
    logic [7:0] scratch_low_byte;
    logic [7:0] scratch_high_byte;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic hs_on;
    logic ls_on;
  } pcr_regs_s;

  localparam pcr_regs_s PCR_REGS_RST = '{
    duty_setting: PCR_RST_DUTY,
    period_rate_select: PCR_RST_RATE,
    thermal_trip_level: PCR_RST_HWC3[PCR_TSD_BIT],
    regulator_current_limit_trim:
      PCR_RST_HWC3[PCR_TRIM_LSB +: PCR_TRIM_W],
    scratch_low_byte: PCR_RST_SCR,
    scratch_high_byte: PCR_RST_SCR,
    rdata: 32'h0000_0000,
    ready: 1'b0,
    slverr: 1'b0,
    hs_on: 1'b0,
    ls_on: 1'b0
  };

  pcr_regs_s st_ff;
  pcr_regs_s nxt_st;
  logic pwm_on;
  logic setup_ph;
  logic wr_acc;
  logic hit;

  // pwm time base sees the live settings, latches them per period
  pcr_pwm #(
    .DUTY_W(PCR_DUTY_W)
  ) u_pwm (
    .clk_i(CLK_SYS_I),
    .nrst_i(NRST_I),
    .soft_rst_i(SOFT_RST_I),
    .duty_i(st_ff.duty_setting),
    .rate_i(st_ff.period_rate_select),
    .on_o(pwm_on)
  );

  // apb phase decode; the slave always answers in the first access cycle
  assign setup_ph = PSEL_I && !PENABLE_I;
  assign wr_acc = PSEL_I && PENABLE_I && st_ff.ready && PWRITE_I;

  // address decode: word aligned, one of five registers
  always_comb begin
    hit = 1'b0;
    if (PADDR_I[1:0] == 2'b00) begin
      unique case (PADDR_I)
        PCR_ADR_DUTY, PCR_ADR_RATE, PCR_ADR_HWC3,
        PCR_ADR_SCRL, PCR_ADR_SCRH: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // register updates, read data and switch outputs
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ready = setup_ph && !st_ff.ready;
    nxt_st.slverr = setup_ph && !st_ff.ready && !hit;
    // read data captured in setup so it is ready in the access cycle
    nxt_st.rdata = 32'h0000_0000;
    if (setup_ph && !PWRITE_I && hit) begin
      unique case (PADDR_I)
        PCR_ADR_DUTY: nxt_st.rdata[7:0] = st_ff.duty_setting;
        // upper bits stay zero: reserved reads as zero
        PCR_ADR_RATE:
          nxt_st.rdata[PCR_RATE_W-1:0] = st_ff.period_rate_select;
        PCR_ADR_HWC3: begin
          nxt_st.rdata[PCR_TSD_BIT] = st_ff.thermal_trip_level;
          nxt_st.rdata[PCR_TRIM_LSB +: PCR_TRIM_W] =
            st_ff.regulator_current_limit_trim;
        end
        // reads allowed in any mode, stop included
        PCR_ADR_SCRL: nxt_st.rdata[7:0] = st_ff.scratch_low_byte;
        PCR_ADR_SCRH: nxt_st.rdata[7:0] = st_ff.scratch_high_byte;
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // writes take effect at the access edge only
    if (wr_acc && hit) begin
      unique case (PADDR_I)
        PCR_ADR_DUTY: nxt_st.duty_setting = PWDATA_I[7:0];
        // only the rate field is stored, others dropped
        PCR_ADR_RATE: nxt_st.period_rate_select =
          PWDATA_I[PCR_RATE_W-1:0];
        PCR_ADR_HWC3: begin
          // lockable fields frozen while the level one lock is set
          if (!CFG_LOCK1_I) begin
            nxt_st.thermal_trip_level = PWDATA_I[PCR_TSD_BIT];
            nxt_st.regulator_current_limit_trim =
              PWDATA_I[PCR_TRIM_LSB +: PCR_TRIM_W];
          end
        end
        // scratch only in normal mode; device logic never writes it
        PCR_ADR_SCRL: begin
          if (NORMAL_MODE_I) begin
            nxt_st.scratch_low_byte = PWDATA_I[7:0];
          end
        end
        PCR_ADR_SCRH: begin
          if (NORMAL_MODE_I) begin
            nxt_st.scratch_high_byte = PWDATA_I[7:0];
          end
        end
        default: nxt_st.duty_setting = st_ff.duty_setting;
      endcase
    end
    // soft reset outranks a write; scratch bytes untouched
    if (SOFT_RST_I) begin
      nxt_st.duty_setting = PCR_RST_DUTY;
      nxt_st.period_rate_select = PCR_RST_RATE;
      // locked settings keep their value like a restart
      if (!CFG_LOCK1_I) begin
        nxt_st.thermal_trip_level = PCR_RST_HWC3[PCR_TSD_BIT];
        nxt_st.regulator_current_limit_trim =
          PCR_RST_HWC3[PCR_TRIM_LSB +: PCR_TRIM_W];
      end
    end
    // pin hand-off decides which side the pwm drives
    nxt_st.ls_on = pwm_on && (PIN_CFG_I == PCR_CFG_LS_PWM);
    nxt_st.hs_on = pwm_on && (PIN_CFG_I == PCR_CFG_HS_PWM);
  end

  // power-on reset is the only thing that clears scratch
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_ff <= PCR_REGS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs all straight from the state register
  assign PRDATA_O = st_ff.rdata;
  assign PREADY_O = st_ff.ready;
  assign PSLVERR_O = st_ff.slverr;
  assign HS_SWITCH_ON_O = st_ff.hs_on;
  assign LS_SWITCH_ON_O = st_ff.ls_on;
  assign THERMAL_TRIP_LEVEL_O = st_ff.thermal_trip_level;
  assign REGULATOR_CURRENT_LIMIT_TRIM_O = st_ff.regulator_current_limit_trim;
  // low byte is bits 7:0, high byte bits 15:8
  assign SCRATCH_WORD_O = {st_ff.scratch_high_byte,
                           st_ff.scratch_low_byte};

  // checks of the documented behaviour
  AST_PREADY_NEXT: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (setup_ph && !st_ff.ready) |=> (PREADY_O ##1 !PREADY_O)
  ) else $error("pready not one cycle after setup");
  AST_SCR_MODE: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    !NORMAL_MODE_I |=> $stable(SCRATCH_WORD_O)
  ) else $error("scratch changed outside normal mode");
  AST_SCR_SOFT: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (SOFT_RST_I && !wr_acc) |=> $stable(SCRATCH_WORD_O)
  ) else $error("soft reset altered scratch");
  AST_SCR_NOWR: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    !wr_acc |=> $stable(SCRATCH_WORD_O)
  ) else $error("scratch changed without a write");
  AST_LOCK_WR: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    CFG_LOCK1_I |=> ($stable(THERMAL_TRIP_LEVEL_O)
      && $stable(REGULATOR_CURRENT_LIMIT_TRIM_O))
  ) else $error("locked setting changed");
  AST_SOFT_UNLK: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (SOFT_RST_I && !CFG_LOCK1_I) |=> (!THERMAL_TRIP_LEVEL_O
      && REGULATOR_CURRENT_LIMIT_TRIM_O == 2'h1)
  ) else $error("soft reset left trim settings");
  AST_TRIM_WR: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (wr_acc && PADDR_I == PCR_ADR_HWC3 && !CFG_LOCK1_I && !SOFT_RST_I)
      |=> (THERMAL_TRIP_LEVEL_O == $past(PWDATA_I[2])
      && REGULATOR_CURRENT_LIMIT_TRIM_O == $past(PWDATA_I[1:0]))
  ) else $error("thermal or trim write lost");
  AST_RATE_RSVD: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (setup_ph && !st_ff.ready && !PWRITE_I && PADDR_I == PCR_ADR_RATE)
      |=> PRDATA_O[31:2] == 30'h0000_0000
  ) else $error("reserved rate bits read nonzero");
  AST_HWC3_RSVD: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (setup_ph && !st_ff.ready && !PWRITE_I && PADDR_I == PCR_ADR_HWC3)
      |=> PRDATA_O[31:3] == 29'h0000_0000
  ) else $error("reserved control bits read nonzero");
  AST_PIN_SEL: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    PIN_CFG_I[2:1] != 2'b11 |=> (!HS_SWITCH_ON_O && !LS_SWITCH_ON_O)
  ) else $error("switch driven without pwm pin mode");
  AST_SOFT_DUTY: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    SOFT_RST_I |=> ##1 (!HS_SWITCH_ON_O && !LS_SWITCH_ON_O)
  ) else $error("switch on right after soft reset");

  CV_SCR_WRITE: cover property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    wr_acc && PADDR_I == PCR_ADR_SCRH && NORMAL_MODE_I);
  CV_LOCKED_WR: cover property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    wr_acc && PADDR_I == PCR_ADR_HWC3 && CFG_LOCK1_I);
  CV_HS_ON: cover property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    HS_SWITCH_ON_O ##1 !HS_SWITCH_ON_O);
  CV_UNMAPPED: cover property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    PSLVERR_O && PREADY_O);
endmodule : pcr_regs

// >>> tb/pwm_and_system_config_regs_test.sv
`timescale 1ns/100ps
module pwm_and_system_config_regs_test;
  import pcr_pkg::*;
  logic clk, nrst, psel, pen, pwr, srst, norm, lock;
  logic [PCR_AW-1:0] pa;
  logic [31:0] pwd, prd, rd;
  logic rdy, err, hs, ls, thr, e;
  logic [2:0] cfg;
  logic [1:0] trim;
  logic [15:0] scr;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0, t1, t2;

  pcr_regs i_pcr_regs (
    .CLK_SYS_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(rdy), .PSLVERR_O(err), .SOFT_RST_I(srst),
    .NORMAL_MODE_I(norm), .CFG_LOCK1_I(lock), .PIN_CFG_I(cfg),
    .HS_SWITCH_ON_O(hs), .LS_SWITCH_ON_O(ls),
    .THERMAL_TRIP_LEVEL_O(thr),
    .REGULATOR_CURRENT_LIMIT_TRIM_O(trim), .SCRATCH_WORD_O(scr));

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // cycle count, used to time pwm edges
  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] s, x, input string m);
    n_compared++;
    if (s !== x) begin
      fails++;
      $display("BAD %0t %s saw %h want %h", $time, m, s, x);
    end
  endtask : chk

  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic hang(input string m);
    fails++;
    $display("BAD %0t %s wait ran out", $time, m);
    close_out();
  endtask : hang

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 16) hang("apb");
    end while (rdy !== 1'b1);
    rd = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, x}, "read");
    chk(e, 1'b0, "slverr");
  endtask : rdc

  task automatic pulse;
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
  endtask : pulse

  // wait for the high side output to reach a level, bounded
  task automatic wait_hs(input logic v, input int lim);
    int n = 0;
    while (hs !== v) begin
      @(posedge clk);
      n++;
      if (n > lim) hang("pwm");
    end
  endtask : wait_hs

  task automatic t_reset;
    rdc(PCR_ADR_DUTY, 8'h00);
    rdc(PCR_ADR_RATE, 8'h00);
    rdc(PCR_ADR_HWC3, 8'h01);
    rdc(PCR_ADR_SCRL, 8'h00);
    rdc(PCR_ADR_SCRH, 8'h00);
    chk(trim, 2'h1, "trim");
    $display("reset values done");
  endtask : t_reset

  task automatic t_fields;
    apb(1'b1, PCR_ADR_RATE, 32'hFF);
    rdc(PCR_ADR_RATE, 8'h03);
    // every trim code, reserved bits 7:3 written as ones
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, PCR_ADR_HWC3, 32'hFC | 32'(i));
      rdc(PCR_ADR_HWC3, {6'h1, i[1:0]});
      chk(trim, i[1:0], "trim");
      chk(thr, 1'b1, "thermal");
    end
    apb(1'b1, PCR_ADR_HWC3, 32'h01);
    rdc(PCR_ADR_HWC3, 8'h01);
    chk(thr, 1'b0, "thermal");
    apb(1'b0, 8'h04, 32'h0);
    chk(e, 1'b1, "unmapped");
    apb(1'b1, 8'h61, 32'h55);
    chk(e, 1'b1, "misaligned");
    rdc(PCR_ADR_DUTY, 8'h00);
    apb(1'b1, PCR_ADR_RATE, 32'h00);
    $display("fields done");
  endtask : t_fields

  task automatic t_scratch;
    apb(1'b1, PCR_ADR_SCRL, 32'hA5);
    apb(1'b1, PCR_ADR_SCRH, 32'h3C);
    rdc(PCR_ADR_SCRH, 8'h3C);
    chk(scr, 16'h3CA5, "word");
    norm <= 1'b0;
    apb(1'b1, PCR_ADR_SCRL, 32'h00);
    rdc(PCR_ADR_SCRL, 8'hA5);
    norm <= 1'b1;
    apb(1'b1, PCR_ADR_DUTY, 32'h55);
    pulse();
    rdc(PCR_ADR_SCRL, 8'hA5);
    rdc(PCR_ADR_DUTY, 8'h00);
    chk(scr, 16'h3CA5, "word");
    $display("scratch done");
  endtask : t_scratch

  task automatic t_lock;
    apb(1'b1, PCR_ADR_HWC3, 32'h06);
    lock <= 1'b1;
    apb(1'b1, PCR_ADR_HWC3, 32'h00);
    rdc(PCR_ADR_HWC3, 8'h06);
    pulse();
    rdc(PCR_ADR_HWC3, 8'h06);
    chk({thr, trim}, 3'h6, "kept");
    lock <= 1'b0;
    pulse();
    rdc(PCR_ADR_HWC3, 8'h01);
    $display("lock done");
  endtask : t_lock

  task automatic t_por;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t0 = cyc;
    rdc(PCR_ADR_SCRL, 8'h00);
    chk(scr, 16'h0, "word");
    $display("power reset done");
  endtask : t_por

  // first period runs at the reset rate with duty zero, so it is long
  task automatic t_pwm;
    int lo = 0;
    // duty goes in before the pin is handed to the pwm
    apb(1'b1, PCR_ADR_DUTY, 32'h80);
    cfg <= 3'h7;
    apb(1'b1, PCR_ADR_RATE, 32'h03);
    wait_hs(1'b1, 110000);
    t1 = cyc;
    chk(32'(t1 - t0 >= 99960 && t1 - t0 <= 99966), 1, "late");
    wait_hs(1'b0, 30000);
    t2 = cyc;
    chk(32'(t2 - t1), 128 * 98, "on time");
    chk(ls, 1'b0, "ls");
    apb(1'b1, PCR_ADR_DUTY, 32'hFF);
    wait_hs(1'b1, 30000);
    chk(32'(cyc - t2), 127 * 98, "off time");
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (hs !== 1'b1) lo++;
    end
    chk(32'(lo), 0, "full on");
    cfg <= 3'h6;
    repeat (3) @(posedge clk);
    chk({ls, hs}, 2'b10, "low side");
    $display("pwm done");
  endtask : t_pwm

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    pa = 8'h00;
    pwd = 32'h0;
    srst = 1'b0;
    norm = 1'b1;
    lock = 1'b0;
    cfg = 3'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_fields();
    t_scratch();
    t_lock();
    t_por();
    t_pwm();
    close_out();
  end
endmodule : pwm_and_system_config_regs_test
